//--- dv/hed_option_decode_props.sv
// Port checker for the option decoder, bound from the bench top.
// Assumes i_ce held high; keeps its own copy of CONFIG from bus writes.
`timescale 1ns/1ps
`default_nettype none
module hed_props
  import hed_pkg::*;
#(
  parameter int P_BIT_BASE_CYC = 5,
  parameter int P_PULSE_BASE_CYC = 5,
  parameter int P_LED_CYC = 20
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire hed_pkg::hed_bus_s i_bus,
  input wire logic [31:0] o_rdata,
  input wire logic i_button,
  input wire logic i_tx_active,
  input wire logic [3:0] i_serial_top,
  input wire logic [31:0] o_bit_cycles,
  input wire logic [31:0] o_pulse_unit_cycles,
  input wire logic o_damp_en,
  input wire logic o_power_hold,
  input wire logic o_third_switch_pin_oe,
  input wire logic o_collision_run,
  input wire logic o_echo_en,
  input wire logic o_ack_send,
  input wire logic o_prox_hop,
  input wire logic [3:0] o_frame_top,
  input wire logic [15:0] o_sync_count
);
  hed_cfg_s cfg;
  logic [31:0] led_run;
  wire logic [1:0] rr = cfg.radio_rate_select;
  wire logic [31:0] bt = 32'(P_BIT_BASE_CYC * (rr == 2'h0 ? 4 : rr == 2'h1 ? 2 : 1)
    * (cfg.line_code_select ? 2 : 1));
  wire logic [31:0] pu = 32'(P_PULSE_BASE_CYC * (cfg.transponder_rate_select ? 1 : 2));
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      cfg <= '0;
      led_run <= '0;
    end
    else
    begin
      if (i_bus.wr && i_bus.addr == HED_REG_CFG)
        cfg <= hed_cfg_s'(i_bus.wdata);
      // Length of the current indicator pulse
      led_run <= o_third_switch_pin_oe ? led_run + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside read answer");
  a_rdata_config: assert property (i_bus.rd && i_bus.addr == HED_REG_CFG
    |=> o_rdata == 32'($past(cfg))) else $error("config read back wrong");
  a_bit_time: assert property (!$past(i_rst) && $stable(cfg) ##1 $stable(cfg)
    |-> o_bit_cycles == bt) else $error("bit time wrong");
  a_pulse_unit: assert property (!$past(i_rst) && $stable(cfg) ##1 $stable(cfg)
    |-> o_pulse_unit_cycles == pu) else $error("pulse unit wrong");
  a_damp_decode: assert property (o_damp_en == !cfg.tank_damp_off)
    else $error("damping state wrong");
  a_collision_modes: assert property (o_collision_run == (cfg.collision_avoid_en &&
    !cfg.proximity_wake_en) && o_echo_en == (cfg.collision_avoid_en && cfg.proximity_wake_en))
    else $error("collision or echo mode wrong");
  a_frame_top: assert property (cfg.long_serial_en ? o_frame_top == i_serial_top
    : o_frame_top[0] == 1'b0) else $error("frame top bits wrong");
  a_count_step: assert property (i_button && !cfg.late_count_step_en
    |=> o_sync_count == $past(o_sync_count) + 16'h1) else $error("counter step wrong");
  a_power_hold: assert property (i_tx_active |-> o_power_hold)
    else $error("power dropped during transmission");
  a_ack_single: assert property (o_ack_send |=> !o_ack_send && !o_prox_hop)
    else $error("acknowledge not a single pulse");
  a_led_gate: assert property (o_third_switch_pin_oe |-> cfg.led_en)
    else $error("indicator driven while disabled");
  a_led_span: assert property (led_run <= 32'(P_LED_CYC))
    else $error("indicator pulse too long");
  c_ack: cover property (o_ack_send);
  c_hop: cover property (o_prox_hop);
  c_led: cover property ($rose(o_third_switch_pin_oe));
endmodule
`default_nettype wire

//--- dv/hed_rx_model.sv
// Receiving decoder model: drains the word stream, stalling on request.
// Assumes each word carries its discrimination value in bits 9..0.
`timescale 1ns/1ps
`default_nettype none
module hed_rx_model #(
  parameter logic [9:0] P_DISC = 10'h2a5
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_stall,
  input wire logic [31:0] i_word,
  input wire logic i_word_valid,
  output logic o_word_ready,
  output logic [7:0] o_good
);
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_word_ready <= 1'b0;
      o_good <= 8'h0;
    end
    else
    begin
      o_word_ready <= !i_stall;
      // Trust a word only when its discrimination value matches
      if (i_word_valid && o_word_ready && i_word[9:0] == P_DISC)
        o_good <= o_good + 8'h1;
    end
  end
endmodule
`default_nettype wire

//--- dv/hopping_encoder_option_decode_tb_top.sv
// Self-checking bench for the option decoder with a decoder model on its word stream.
// Assumes short timer parameters; i_ce is held high throughout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module hopping_encoder_option_decode_tb_top;
  import hed_pkg::*;
  localparam int P_BB = 5;
  localparam int P_PB = 5;
  localparam int P_LED = 20;
  localparam int P_PW = 20;
  localparam int P_PH = 30;
  localparam int P_SD = 30;
  localparam logic [9:0] P_DISC = 10'h2a5;
  int num_errors = 0;
  int comparisons = 0;
  hed_bus_s i_bus;
  logic i_ref_clk, i_rst, i_ce, i_button, i_tx_active, i_tx_end, i_low_volt;
  logic i_field_detect, i_start_bit, i_word_valid, i_word_ready, hold, stall;
  logic [2:0] i_switch;
  logic [3:0] i_serial_top, o_rc_trim, o_frame_top;
  logic [31:0] i_word, o_word, o_rdata, o_bit_cycles, o_pulse_unit_cycles;
  logic o_word_ready, o_word_valid, o_manchester, o_damp_en, o_supply_high, o_power_hold;
  logic o_seed_permit, o_send_seed, o_dual_key_mode, o_third_switch_pin_out;
  logic o_third_switch_pin_oe, o_collision_run, o_echo_en, o_ack_send, o_prox_hop;
  logic [15:0] o_sync_count;
  logic [7:0] good;
  hed_option_decode #(.P_BIT_BASE_CYC(P_BB), .P_PULSE_BASE_CYC(P_PB), .P_LED_CYC(P_LED),
    .P_PROX_WAIT_CYC(P_PW), .P_PROX_HOP_CYC(P_PH), .P_SEED_DELAY_CYC(P_SD)) DUT (.*);
  hed_rx_model #(.P_DISC(P_DISC)) u_rx (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_stall(stall), .i_word(o_word), .i_word_valid(o_word_valid),
    .o_word_ready(i_word_ready), .o_good(good));
  // Far side stalls every other cycle, or fully while hold is high
  always @(posedge i_ref_clk)
    stall <= hold | (!stall && !i_rst);
  task automatic final_report();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    final_report();
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge i_ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    i_bus.wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rdchk(logic [7:0] a, logic [31:0] e);
    i_bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    i_bus.rd <= 1'b0;
    @(negedge i_ref_clk);
    `CHK(o_rdata, e)
    @(posedge i_ref_clk);
  endtask
  task automatic setcfg(hed_cfg_s c);
    wr(HED_REG_CFG, 32'(c));
    tick(3);
  endtask
  task automatic press(logic [2:0] f);
    i_switch <= f;
    i_button <= 1'b1;
    @(posedge i_ref_clk);
    i_button <= 1'b0;
    tick(2);
  endtask
  // Leaves valid high so back-to-back pushes keep it asserted with no idle cycle between words
  task automatic push(logic [31:0] w);
    int n;
    i_word_valid <= 1'b1;
    i_word <= w;
    @(negedge i_ref_clk);
    for (n = 0; !o_word_ready && n < 200; n++)
      @(negedge i_ref_clk);
    if (n == 200)
      timeout();
    @(posedge i_ref_clk);
  endtask
  task automatic t_decode();
    hed_cfg_s c;
    int mul[4] = '{4, 2, 1, 1};
    logic [3:0] tr[8] = '{4'h0, 4'h8, 4'h7, 4'hf, 4'h1, 4'h9, 4'h3, 4'hc};
    for (int i = 0; i < 8; i++)
    begin
      c = '0;
      c.radio_rate_select = 2'(i);
      c.line_code_select = i[2];
      c.transponder_rate_select = i[0];
      c.tank_damp_off = i[1];
      c.rc_trim_field = tr[i];
      c.seed_mode = 2'(i >> 1);
      c.collision_avoid_en = i[0];
      c.proximity_wake_en = i[1];
      c.low_batt_high_supply = i[2];
      setcfg(c);
      `CHK(o_bit_cycles, 32'(P_BB * mul[i[1:0]] * (i[2] ? 2 : 1)))
      `CHK(o_pulse_unit_cycles, 32'(P_PB * (i[0] ? 1 : 2)))
      `CHK(o_manchester, 1'(i[2]))
      `CHK(o_damp_en, 1'(!i[1]))
      `CHK(o_rc_trim, tr[i])
      `CHK(o_supply_high, 1'(i[2]))
      `CHK(o_dual_key_mode, 1'(i >= 6))
      `CHK(o_collision_run, 1'(i[0] && !i[1]))
      `CHK(o_echo_en, 1'(i[0] && i[1]))
    end
  endtask
  task automatic t_blank();
    hed_cfg_s c;
    logic [7:0] g0;
    int keep[5] = '{8, 4, 4, 2, 8};
    for (int r = 0; r < 5; r++)
    begin
      c = '0;
      c.word_blank_en = (r < 4);
      c.radio_rate_select = (r == 4) ? 2'h3 : 2'(r);
      setcfg(c);
      press(3'h1);
      g0 = good;
      for (int k = 0; k < 8; k++)
        push({22'(k), P_DISC});
      i_word_valid <= 1'b0;
      tick(40);
      `CHK(8'(good - g0), 8'(keep[r]))
    end
  endtask
  task automatic t_fill();
    int n;
    logic [7:0] g0;
    hold <= 1'b1;
    tick(3);
    g0 = good;
    i_word_valid <= 1'b1;
    i_word <= {22'h0, P_DISC};
    for (n = 0; n < 8; n++)
    begin
      @(negedge i_ref_clk);
      if (!o_word_ready)
        break;
      @(posedge i_ref_clk);
    end
    @(posedge i_ref_clk);
    i_word_valid <= 1'b0;
    hold <= 1'b0;
    `CHK(n, 4)
    tick(30);
    `CHK(8'(good - g0), 8'h4)
    `CHK(o_word_valid, 1'b0)
  endtask
  task automatic t_count();
    hed_cfg_s c;
    c = '0;
    c.seed_mode = HED_SEED_LIMITED;
    setcfg(c);
    wr(HED_REG_COUNT, 32'h0000_007f);
    tick(2);
    `CHK(o_seed_permit, 1'b1)
    press(3'h5);
    `CHK(o_sync_count, 16'h0080)
    `CHK(o_seed_permit, 1'b0)
    `CHK(o_frame_top, 4'ha)
    c.long_serial_en = 1'b1;
    c.late_count_step_en = 1'b1;
    setcfg(c);
    `CHK(o_frame_top, 4'h3)
    press(3'h1);
    `CHK(o_sync_count, 16'h0080)
    i_tx_end <= 1'b1;
    @(posedge i_ref_clk);
    i_tx_end <= 1'b0;
    tick(2);
    `CHK(o_sync_count, 16'h0081)
  endtask
  task automatic t_led(logic en, int e);
    hed_cfg_s c;
    int n;
    c = '0;
    c.led_en = en;
    setcfg(c);
    press(3'h1);
    i_low_volt <= 1'b1;
    i_tx_active <= 1'b1;
    n = 0;
    repeat (3 * P_LED)
    begin
      @(negedge i_ref_clk);
      n += int'(o_third_switch_pin_oe);
    end
    @(posedge i_ref_clk);
    i_low_volt <= 1'b0;
    i_tx_active <= 1'b0;
    `CHK(n, e)
  endtask
  task automatic t_prox();
    hed_cfg_s c;
    int n;
    c = '0;
    c.proximity_wake_en = 1'b1;
    setcfg(c);
    i_field_detect <= 1'b1;
    @(posedge i_ref_clk);
    i_field_detect <= 1'b0;
    @(negedge i_ref_clk);
    `CHK(o_ack_send, 1'b1)
    n = 0;
    repeat (P_PW + P_PH + 20)
    begin
      @(negedge i_ref_clk);
      n += int'(o_prox_hop);
    end
    `CHK(n, P_PH)
    @(posedge i_ref_clk);
    // A start bit inside the wait window cancels the hopping burst
    i_field_detect <= 1'b1;
    @(posedge i_ref_clk);
    i_field_detect <= 1'b0;
    tick(5);
    i_start_bit <= 1'b1;
    @(posedge i_ref_clk);
    i_start_bit <= 1'b0;
    n = 0;
    repeat (P_PW + P_PH)
    begin
      @(negedge i_ref_clk);
      n += int'(o_prox_hop);
    end
    `CHK(n, 0)
    @(posedge i_ref_clk);
  endtask
  task automatic t_seed();
    hed_cfg_s c;
    c = '0;
    c.seed_mode = HED_SEED_ALWAYS;
    c.min_three_words = 1'b1;
    setcfg(c);
    press(3'h7);
    `CHK(o_send_seed, 1'b1)
    `CHK(o_power_hold, 1'b1)
    for (int k = 0; k < 3; k++)
      push({22'(k), P_DISC});
    i_word_valid <= 1'b0;
    tick(12);
    `CHK(o_power_hold, 1'b0)
    press(3'h3);
    i_tx_active <= 1'b1;
    tick(P_SD - 10);
    `CHK(o_send_seed, 1'b0)
    `CHK(o_power_hold, 1'b1)
    tick(20);
    `CHK(o_send_seed, 1'b1)
    i_tx_active <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    tick(20000);
    timeout();
  end
  initial
  begin
    {i_rst, i_ce, i_bus, i_button, i_switch, i_tx_active, i_tx_end} = '0;
    {i_low_volt, i_field_detect, i_start_bit, i_word, i_word_valid, hold} = '0;
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_serial_top = 4'h3;
    tick(16);
    i_rst <= 1'b0;
    rdchk(HED_REG_CFG, HED_CFG_RST);
    rdchk(HED_REG_COUNT, 32'(HED_COUNT_RST));
    rdchk(8'h0c, 32'h0);
    wr(HED_REG_CFG, 32'h0005_a5a4);
    rdchk(HED_REG_CFG, 32'h0005_a5a4);
    t_decode();
    t_blank();
    t_fill();
    t_count();
    t_led(1'b1, P_LED);
    t_led(1'b0, 0);
    t_prox();
    t_seed();
    final_report();
  end
endmodule
bind hed_option_decode hed_props #(.P_BIT_BASE_CYC(P_BIT_BASE_CYC),
  .P_PULSE_BASE_CYC(P_PULSE_BASE_CYC), .P_LED_CYC(P_LED_CYC)) u_props (.*);
`default_nettype wire

//--- verilog/hed_option_decode.sv
// Option decoder of a code hopping encoder: config register, word FIFO with
// blanking, timers for indicator, proximity wake and delayed seed.
// Assumes all inputs synchronous to i_ref_clk and a plain strobe register port.
`timescale 1ns/1ps
`default_nettype none

module hed_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [W-1:0] i_data,
  input wire logic i_valid,
  output logic o_ready,
  output logic [W-1:0] o_data,
  output logic o_valid,
  input wire logic i_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_s;
  fifo_s st;
  fifo_s next_st;
  logic push;
  logic pop;

  assign o_ready = (st.cnt != (AW+1)'(D));
  assign o_valid = (st.cnt != '0);
  assign o_data = st.mem[st.rp];
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = i_data;
      next_st.wp = (st.wp == AW'(D-1)) ? '0 : st.wp + 1'b1;
    end
    if (pop)
    begin
      next_st.rp = (st.rp == AW'(D-1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      st <= '0;
    else if (i_ce)
      st <= next_st;
  end
endmodule

// Overview of operation
// - With blanking on, send all, one of two, or one of four words by rate.
// - Damping-off bit set disables tank damping; clear keeps it on.
// - Seed mode: none, limited, always, dual key; limited ends past low byte 7F.
// - Four-bit trim: 0000 nominal, 1000 fastest, 0111 slowest.
// - Minimum-words set: hold power until three words sent.
// - Supply select bit picks 5/6 V class when set, 3.0 V when clear.
// - On low supply, indicator lights once for 200 ms in a hopping transmission.
// - Indicator enable makes the third switch pin also an indicator output.
// - Transponder rate bit: 200 us pulse unit clear, 100 us set; both ends agree.
// - Line code bit picks Manchester when 1, pulse width when 0.
// - Anti-collision without proximity wake runs anti-collision handling.
// - Proximity wake alone: acknowledge on field, 50 ms wait, then 2 s hopping.
// - Both set: transponder responses are echoed on pulse-width pin.
// - Delayed-increment bit on delays counter step; off steps once per press.
// - Long serial puts serial top bits in frame 60..63, else switches and zero.
// - Delayed seed code sends hopping frames three seconds, then seed frames.
module hed_option_decode
  import hed_pkg::*;
#(
  parameter int P_BIT_BASE_CYC = hed_pkg::HED_BIT_BASE_CYC,
  parameter int P_PULSE_BASE_CYC = hed_pkg::HED_PULSE_BASE_CYC,
  parameter int P_LED_CYC = hed_pkg::HED_LED_CYC,
  parameter int P_PROX_WAIT_CYC = hed_pkg::HED_PROX_WAIT_CYC,
  parameter int P_PROX_HOP_CYC = hed_pkg::HED_PROX_HOP_CYC,
  parameter int P_SEED_DELAY_CYC = hed_pkg::HED_SEED_DELAY_CYC,
  parameter int P_WORD_W = 32,
  parameter int P_FIFO_D = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire hed_pkg::hed_bus_s i_bus,
  output logic [31:0] o_rdata,
  input wire logic i_button,
  input wire logic [2:0] i_switch,
  input wire logic i_tx_active,
  input wire logic i_tx_end,
  input wire logic i_low_volt,
  input wire logic i_field_detect,
  input wire logic i_start_bit,
  input wire logic [3:0] i_serial_top,
  input wire logic [P_WORD_W-1:0] i_word,
  input wire logic i_word_valid,
  output logic o_word_ready,
  output logic [P_WORD_W-1:0] o_word,
  output logic o_word_valid,
  input wire logic i_word_ready,
  output logic [31:0] o_bit_cycles,
  output logic [31:0] o_pulse_unit_cycles,
  output logic o_manchester,
  output logic o_damp_en,
  output logic [3:0] o_rc_trim,
  output logic o_supply_high,
  output logic o_power_hold,
  output logic o_seed_permit,
  output logic o_send_seed,
  output logic o_dual_key_mode,
  output logic o_third_switch_pin_out,
  output logic o_third_switch_pin_oe,
  output logic o_collision_run,
  output logic o_echo_en,
  output logic o_ack_send,
  output logic o_prox_hop,
  output logic [3:0] o_frame_top,
  output logic [15:0] o_sync_count
);
  import hed_pkg::*;

  typedef struct packed {
    logic [31:0] cfg;
    logic [15:0] count;
    logic step_due;
    logic seed_spent;
    logic [31:0] rdata;
    logic [1:0] blank_phase;
    logic [1:0] words_sent;
    logic led_on;
    logic led_done;
    logic [HED_TMR_W-1:0] led_tmr;
    hed_prox_e prox;
    logic [HED_TMR_W-1:0] prox_tmr;
    logic [HED_TMR_W-1:0] seed_tmr;
    logic seed_late_done;
    logic [2:0] fn;
    logic [31:0] bit_cyc;
    logic [31:0] pulse_cyc;
  } hed_state_s;

  hed_state_s st;
  hed_state_s next_st;
  hed_cfg_s cfg;
  logic [P_WORD_W-1:0] q_word;
  logic q_valid;
  logic q_ready;
  logic word_keep;
  logic word_pop;
  logic step_now;

  // Which of the queued words survive blanking
  function automatic logic keep_word(input logic en, input logic [1:0] rate,
                                     input logic [1:0] phase);
    logic k;
    k = 1'b1;
    if (en)
    begin
      case (rate)
        2'h0: k = 1'b1;
        2'h1: k = (phase[0] == 1'b0);
        2'h2: k = (phase[0] == 1'b0);
        2'h3: k = (phase == 2'h0);
        default: k = 1'b1;
      endcase
    end
    return k;
  endfunction

  function automatic logic [31:0] rate_mult(input logic [1:0] rate);
    logic [31:0] m;
    case (rate)
      2'h0: m = 32'h4;
      2'h1: m = 32'h2;
      default: m = 32'h1;
    endcase
    return m;
  endfunction

  assign cfg = hed_cfg_s'(st.cfg);

  hed_fifo #(
    .W(P_WORD_W),
    .D(P_FIFO_D)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_data(i_word),
    .i_valid(i_word_valid),
    .o_ready(o_word_ready),
    .o_data(q_word),
    .o_valid(q_valid),
    .i_ready(q_ready)
  );

  // Blanked words are drained silently; kept words wait for the transmitter
  assign word_keep = keep_word(cfg.word_blank_en, cfg.radio_rate_select, st.blank_phase);
  assign q_ready = word_keep ? i_word_ready : 1'b1;
  assign word_pop = q_valid && q_ready;
  assign o_word_valid = q_valid && word_keep;
  assign o_word = q_word;

  // Immediate step on press, or deferred to the end of the transmission
  assign step_now = cfg.late_count_step_en ? (st.step_due && i_tx_end) : i_button;

  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h0;

    // Register port
    if (i_bus.wr)
    begin
      case (i_bus.addr)
        HED_REG_CFG: next_st.cfg = i_bus.wdata;
        HED_REG_COUNT: next_st.count = i_bus.wdata[15:0];
        default: next_st.cfg = st.cfg;
      endcase
    end
    if (i_bus.rd)
    begin
      case (i_bus.addr)
        HED_REG_CFG: next_st.rdata = st.cfg;
        HED_REG_STATUS: next_st.rdata = {9'h0, st.seed_late_done, st.words_sent,
                                         st.prox, st.led_on, st.seed_spent, st.count};
        HED_REG_COUNT: next_st.rdata = {16'h0, st.count};
        default: next_st.rdata = 32'h0;
      endcase
    end

    // Bit time and pulse unit
    next_st.bit_cyc = 32'(P_BIT_BASE_CYC) * rate_mult(cfg.radio_rate_select);
    if (cfg.line_code_select)
      next_st.bit_cyc = next_st.bit_cyc << 1;
    next_st.pulse_cyc = cfg.transponder_rate_select ? 32'(P_PULSE_BASE_CYC)
                                                    : 32'(P_PULSE_BASE_CYC) << 1;

    // Activation starts a fresh word sequence
    if (i_button)
    begin
      next_st.fn = i_switch;
      next_st.blank_phase = 2'h0;
      next_st.words_sent = 2'h0;
      next_st.led_done = 1'b0;
      next_st.seed_tmr = '0;
      next_st.seed_late_done = 1'b0;
      next_st.step_due = cfg.late_count_step_en;
    end
    else if (word_pop)
    begin
      next_st.blank_phase = st.blank_phase + 2'h1;
      if (word_keep && st.words_sent != 2'(HED_MIN_WORDS))
        next_st.words_sent = st.words_sent + 2'h1;
    end

    // Counter step and the limited-seed boundary
    if (step_now)
    begin
      next_st.count = st.count + 16'h1;
      // A press landing with the deferred step stays pending
      next_st.step_due = i_button && cfg.late_count_step_en;
      if (st.count[7:0] == HED_LIMIT_LOW_BYTE)
        next_st.seed_spent = 1'b1;
    end

    // Delayed seed: hopping frames first, seed after the delay
    if (!i_button && i_tx_active && st.fn == HED_FN_SEED_LATE && !st.seed_late_done)
    begin
      if (st.seed_tmr == HED_TMR_W'(P_SEED_DELAY_CYC - 1))
        next_st.seed_late_done = 1'b1;
      else
        next_st.seed_tmr = st.seed_tmr + 1'b1;
    end

    // One indicator flash per transmission on low supply
    if (st.led_on)
    begin
      if (st.led_tmr == HED_TMR_W'(P_LED_CYC - 1))
      begin
        next_st.led_on = 1'b0;
        next_st.led_tmr = '0;
      end
      else
        next_st.led_tmr = st.led_tmr + 1'b1;
    end
    else if (i_low_volt && i_tx_active && !st.led_done && !i_button)
    begin
      next_st.led_on = 1'b1;
      next_st.led_done = 1'b1;
      next_st.led_tmr = '0;
    end

    // Proximity wake sequence, only with anti-collision clear
    case (st.prox)
      HED_PX_IDLE:
      begin
        next_st.prox_tmr = '0;
        if (cfg.proximity_wake_en && !cfg.collision_avoid_en && i_field_detect)
          next_st.prox = HED_PX_ACK;
      end
      HED_PX_ACK:
      begin
        next_st.prox_tmr = '0;
        next_st.prox = HED_PX_WAIT;
      end
      HED_PX_WAIT:
      begin
        if (i_start_bit)
          next_st.prox = HED_PX_IDLE;
        else if (st.prox_tmr == HED_TMR_W'(P_PROX_WAIT_CYC - 1))
        begin
          next_st.prox = HED_PX_HOP;
          next_st.prox_tmr = '0;
        end
        else
          next_st.prox_tmr = st.prox_tmr + 1'b1;
      end
      HED_PX_HOP:
      begin
        if (st.prox_tmr == HED_TMR_W'(P_PROX_HOP_CYC - 1))
          next_st.prox = HED_PX_IDLE;
        else
          next_st.prox_tmr = st.prox_tmr + 1'b1;
      end
      default: next_st.prox = HED_PX_IDLE;
    endcase
    if (!cfg.proximity_wake_en || cfg.collision_avoid_en)
      next_st.prox = HED_PX_IDLE;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.cfg <= HED_CFG_RST;
      st.count <= HED_COUNT_RST;
      st.prox <= HED_PX_IDLE;
    end
    else if (i_ce)
      st <= next_st;
  end

  assign o_rdata = st.rdata;
  assign o_sync_count = st.count;
  assign o_bit_cycles = st.bit_cyc;
  assign o_pulse_unit_cycles = st.pulse_cyc;
  assign o_manchester = cfg.line_code_select;
  assign o_damp_en = !cfg.tank_damp_off;
  assign o_rc_trim = cfg.rc_trim_field;
  assign o_supply_high = cfg.low_batt_high_supply;

  // Hold power while sending, or until the minimum word count is out
  assign o_power_hold = i_tx_active
                        || (cfg.min_three_words && st.words_sent != 2'(HED_MIN_WORDS));

  assign o_dual_key_mode = (cfg.seed_mode == HED_SEED_DUAL);
  assign o_seed_permit = (cfg.seed_mode == HED_SEED_ALWAYS)
                         || (cfg.seed_mode == HED_SEED_LIMITED && !st.seed_spent);
  assign o_send_seed = o_seed_permit
                       && (st.fn == HED_FN_SEED
                           || (st.fn == HED_FN_SEED_LATE && st.seed_late_done));

  // Pin drives high only while the indicator is lit
  assign o_third_switch_pin_out = 1'b1;
  assign o_third_switch_pin_oe = cfg.led_en && st.led_on;

  assign o_collision_run = cfg.collision_avoid_en && !cfg.proximity_wake_en;
  assign o_echo_en = cfg.collision_avoid_en && cfg.proximity_wake_en;
  assign o_ack_send = (st.prox == HED_PX_ACK);
  assign o_prox_hop = (st.prox == HED_PX_HOP);
  assign o_frame_top = cfg.long_serial_en ? i_serial_top : {st.fn, 1'b0};

endmodule

`default_nettype wire

//--- verilog/hed_pkg.sv
// Constants, register map and carrier types for the hopping encoder option decoder.
// Assumes a single 200 MHz clock; all times below are turned into cycles here.
package hed_pkg;

  localparam int HED_CLK_MHZ = 200;

  // Times in their own units, then in clock cycles
  localparam int HED_BIT_BASE_US = 100;
  localparam int HED_PULSE_BASE_US = 100;
  localparam int HED_LED_MS = 200;
  localparam int HED_PROX_WAIT_MS = 50;
  localparam int HED_PROX_HOP_S = 2;
  localparam int HED_SEED_DELAY_S = 3;
  localparam int HED_BIT_BASE_CYC = HED_BIT_BASE_US * HED_CLK_MHZ;
  localparam int HED_PULSE_BASE_CYC = HED_PULSE_BASE_US * HED_CLK_MHZ;
  localparam int HED_LED_CYC = HED_LED_MS * 1000 * HED_CLK_MHZ;
  localparam int HED_PROX_WAIT_CYC = HED_PROX_WAIT_MS * 1000 * HED_CLK_MHZ;
  localparam int HED_PROX_HOP_CYC = HED_PROX_HOP_S * 1000000 * HED_CLK_MHZ;
  localparam int HED_SEED_DELAY_CYC = HED_SEED_DELAY_S * 1000000 * HED_CLK_MHZ;
  localparam int HED_TMR_W = 30;
  localparam int HED_MIN_WORDS = 3;

  // Register map, byte addresses
  localparam logic [7:0] HED_REG_CFG = 8'h00;
  localparam logic [7:0] HED_REG_STATUS = 8'h04;
  localparam logic [7:0] HED_REG_COUNT = 8'h08;
  localparam logic [31:0] HED_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] HED_COUNT_RST = 16'h0000;

  // Field codes
  localparam logic [1:0] HED_SEED_NONE = 2'h0;
  localparam logic [1:0] HED_SEED_LIMITED = 2'h1;
  localparam logic [1:0] HED_SEED_ALWAYS = 2'h2;
  localparam logic [1:0] HED_SEED_DUAL = 2'h3;
  localparam logic [7:0] HED_LIMIT_LOW_BYTE = 8'h7f;
  localparam logic [2:0] HED_FN_SEED = 3'h7;
  localparam logic [2:0] HED_FN_SEED_LATE = 3'h3;

  // Configuration word, bit 0 at the bottom
  typedef struct packed {
    logic [12:0] unused;
    logic long_serial_en;
    logic late_count_step_en;
    logic proximity_wake_en;
    logic collision_avoid_en;
    logic line_code_select;
    logic transponder_rate_select;
    logic [1:0] radio_rate_select;
    logic led_en;
    logic low_batt_high_supply;
    logic min_three_words;
    logic [3:0] rc_trim_field;
    logic [1:0] seed_mode;
    logic tank_damp_off;
    logic word_blank_en;
  } hed_cfg_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hed_bus_s;

  typedef enum logic [1:0] {
    HED_PX_IDLE = 2'b00,
    HED_PX_ACK = 2'b01,
    HED_PX_WAIT = 2'b10,
    HED_PX_HOP = 2'b11
  } hed_prox_e;

endpackage
